// [shared/iskr_pkg.sv]
// constants, layouts and state types for the command interpreter
//
// Behaviour
// - nonce mode 00 mixes fresh random, refreshes seed
// - nonce mode 01 keeps seed, mixes random
// - nonce mode 11 loads input; 10 invalid
// - pause mismatch enters idle, no result
// - pause match stays awake, returns zero byte
// - pause only idles, never sleeps
// - key write 0x46, bit6 encrypted, slot, MAC
// - key write needs private flag and secret
// - key write refused on locked slot
// - config zone unlocked means key write error
// - before data lock, MAC only when encrypted
// - after data lock, policy must be encrypt
// - after data lock, digest key must match
// - decrypt with temp key and its hash
// - device verifies MAC over plaintext message
// - key write ignores random and auth fields
// - key write success returns zero byte
// - random 0x1B, param2 zero, returns 32 bytes
// - config unlocked gives FF FF 00 00 pattern
// - random mode bit0 selects seed refresh
package iskr_pkg;
  localparam logic [7:0] OP_PAUSE = 8'h01;
  localparam logic [7:0] OP_NONCE = 8'h16;
  localparam logic [7:0] OP_RANDOM = 8'h1B;
  localparam logic [7:0] OP_PRIV_WRITE = 8'h46;
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_MAC_FAIL = 8'h01;
  localparam logic [7:0] ST_PARSE = 8'h03;
  localparam logic [7:0] ST_EXEC = 8'h0F;
  localparam logic [1:0] NMODE_SEED = 2'h0;
  localparam logic [1:0] NMODE_KEEP = 2'h1;
  localparam logic [1:0] NMODE_BAD = 2'h2;
  localparam logic [1:0] NMODE_PASS = 2'h3;
  localparam int NONCE_SUBST_BIT = 15;
  localparam int PW_ENC_BIT = 6;
  localparam int RND_KEEP_BIT = 0;
  localparam logic [3:0] WRITE_POLICY_ENCRYPT = 4'h4;
  localparam logic [31:0] TEST_PATTERN_WORD = 32'h0000_FFFF;
  localparam logic [11:0] ADDR_CMD = 12'h000;
  localparam logic [11:0] ADDR_CTRL = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_TKSTAT = 12'h00C;
  localparam logic [11:0] ADDR_BUF_BASE = 12'h040;
  localparam logic [11:0] ADDR_RES_BASE = 12'h0C0;
  localparam int BUF_WORDS = 17;
  localparam int RES_WORDS = 8;
  localparam int KEY_WORDS = 9;
  localparam int CTRL_START_BIT = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_IDLE = 2;
  localparam int STAT_CODE_LSB = 8;
  localparam int STAT_LEN_LSB = 16;
  localparam logic [1:0] HASH_NONCE = 2'h0;
  localparam logic [1:0] HASH_TK = 2'h1;
  localparam logic [1:0] HASH_MAC = 2'h2;
  localparam logic [5:0] LEN_NONE = 6'h00;
  localparam logic [5:0] LEN_BYTE = 6'h01;
  localparam logic [5:0] LEN_RAND = 6'h20;

  // command word as software writes it: opcode in the low byte
  typedef struct packed {
    logic [15:0] param2;
    logic [7:0] param1;
    logic [7:0] opcode;
  } iskr_cmd_s;

  // configuration of the slot named by the command
  typedef struct packed {
    logic private_key_flag;
    logic secret_flag;
    logic per_slot_lock;
    logic [3:0] write_policy;
    logic [3:0] write_key_index;
  } iskr_slot_cfg_s;

  // temp key register flags
  typedef struct packed {
    logic valid;
    logic src_input;
    logic digest_generation_cmd;
    logic [3:0] key_id;
  } iskr_tk_meta_s;

  typedef enum logic [1:0] {S_IDLE, S_DECODE, S_HASH} iskr_state_e;

  // whole state of the interpreter
  typedef struct packed {
    iskr_state_e state;
    iskr_cmd_s cmd;
    logic [BUF_WORDS-1:0][31:0] dbuf;
    logic [7:0][31:0] temp_key;
    iskr_tk_meta_s tk;
    logic [7:0][31:0] rand_val;
    logic [KEY_WORDS-1:0][31:0] operand;
    logic [1:0] hash_kind;
    logic busy;
    logic done;
    logic idle;
    logic [7:0] status;
    logic [5:0] out_len;
    logic key_write;
    logic idle_req;
    logic seed_upd;
    logic [31:0] prdata;
  } iskr_regs_s;
endpackage

// [hdl/iskr_core.sv]
// command interpreter for pause, nonce, key write and random commands
`timescale 1ns/1ps
module iskr_core (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [7:0] i_selector,
  input wire logic i_config_locked,
  input wire logic i_data_locked,
  input wire iskr_pkg::iskr_slot_cfg_s i_slot_cfg,
  output logic [3:0] o_slot_index,
  input wire logic [255:0] i_rng_data,
  output logic o_seed_update,
  input wire logic i_digest_generation_cmd_load,
  input wire logic [3:0] i_digest_generation_cmd_key_id,
  input wire logic [255:0] i_digest_generation_cmd_digest,
  output logic o_hash_req,
  output logic [1:0] o_hash_kind,
  input wire logic i_hash_done,
  input wire logic [255:0] i_hash_digest,
  output logic [255:0] o_temp_key,
  output iskr_pkg::iskr_tk_meta_s o_tk_meta,
  output logic [255:0] o_rand_value,
  output logic [287:0] o_operand,
  output iskr_pkg::iskr_cmd_s o_cmd,
  output logic o_key_write,
  output logic o_idle_req
);
  iskr_pkg::iskr_regs_s r; // registered state
  iskr_pkg::iskr_regs_s n; // next state

  // apb decode
  logic setup; // setup phase, read data is captured here
  logic access; // access phase, always completes in one cycle
  logic sel_cmd;
  logic sel_ctrl;
  logic sel_stat;
  logic sel_tk;
  logic sel_buf;
  logic sel_res;
  logic [11:0] buf_off; // byte offset inside the data buffer
  logic [11:0] res_off; // byte offset inside the result window
  logic [4:0] buf_idx;
  logic [2:0] res_idx;
  logic mapped;
  logic writable; // status and results are read only
  logic wr_ok;
  logic [31:0] rd_data;
  logic [255:0] rng_word; // generator output or the test pattern
  logic [7:0] p1; // shorthand for the current parameters
  logic [15:0] p2;

  assign setup = i_psel && !i_penable;
  assign access = i_psel && i_penable;
  assign buf_off = i_paddr - iskr_pkg::ADDR_BUF_BASE;
  assign res_off = i_paddr - iskr_pkg::ADDR_RES_BASE;
  assign buf_idx = buf_off[6:2];
  assign res_idx = res_off[4:2];
  assign sel_cmd = i_paddr == iskr_pkg::ADDR_CMD;
  assign sel_ctrl = i_paddr == iskr_pkg::ADDR_CTRL;
  assign sel_stat = i_paddr == iskr_pkg::ADDR_STATUS;
  assign sel_tk = i_paddr == iskr_pkg::ADDR_TKSTAT;
  assign sel_buf = i_paddr >= iskr_pkg::ADDR_BUF_BASE && i_paddr[1:0] == 2'h0
    && buf_off < 12'(4 * iskr_pkg::BUF_WORDS);
  assign sel_res = i_paddr >= iskr_pkg::ADDR_RES_BASE && i_paddr[1:0] == 2'h0
    && res_off < 12'(4 * iskr_pkg::RES_WORDS);
  assign mapped = sel_cmd || sel_ctrl || sel_stat || sel_tk || sel_buf
    || sel_res;
  assign writable = sel_cmd || sel_ctrl || sel_buf;
  // writes during a command would corrupt its operands, so they fail
  assign wr_ok = access && i_pwrite && writable && !r.busy;
  assign o_pready = access;
  assign o_pslverr = access && (!mapped
    || (i_pwrite && (!writable || r.busy)));
  assign o_prdata = r.prdata;

  // the generator is replaced by a fixed pattern until config lock
  assign rng_word = i_config_locked ? i_rng_data
    : {8{iskr_pkg::TEST_PATTERN_WORD}};
  assign p1 = r.cmd.param1;
  assign p2 = r.cmd.param2;

  // read mux, sampled into prdata during setup
  always_comb begin
    rd_data = 32'h0000_0000;
    if (sel_cmd) begin
      rd_data = r.cmd;
    end else if (sel_stat) begin
      rd_data[iskr_pkg::STAT_BUSY] = r.busy;
      rd_data[iskr_pkg::STAT_DONE] = r.done;
      rd_data[iskr_pkg::STAT_IDLE] = r.idle;
      rd_data[iskr_pkg::STAT_CODE_LSB +: 8] = r.status;
      rd_data[iskr_pkg::STAT_LEN_LSB +: 6] = r.out_len;
    end else if (sel_tk) begin
      rd_data[6:0] = r.tk;
    end else if (sel_buf) begin
      rd_data = r.dbuf[buf_idx];
    end else if (sel_res) begin
      rd_data = r.rand_val[res_idx];
    end
  end

  // next state: bus, temp key loads and the command sequencer
  always_comb begin
    n = r;
    n.key_write = 1'b0;
    n.idle_req = 1'b0;
    n.seed_upd = 1'b0;
    if (setup) begin
      n.prdata = rd_data;
    end
    // digest results from the outside command only land between commands
    if (i_digest_generation_cmd_load && !r.busy) begin
      n.temp_key = i_digest_generation_cmd_digest;
      n.tk = '{valid: 1'b1, src_input: 1'b0, digest_generation_cmd: 1'b1,
        key_id: i_digest_generation_cmd_key_id};
    end
    if (wr_ok) begin
      if (sel_cmd) begin
        n.cmd = i_pwdata;
      end else if (sel_ctrl && i_pwdata[iskr_pkg::CTRL_START_BIT]) begin
        n.busy = 1'b1;
        n.done = 1'b0;
        n.state = iskr_pkg::S_DECODE;
      end else if (sel_buf) begin
        n.dbuf[buf_idx] = i_pwdata;
      end
    end
    unique case (r.state)
      iskr_pkg::S_IDLE: begin
        // waiting for a start write
      end
      iskr_pkg::S_DECODE: begin
        // default ending: done with success and no data
        n.state = iskr_pkg::S_IDLE;
        n.busy = 1'b0;
        n.done = 1'b1;
        n.status = iskr_pkg::ST_OK;
        n.out_len = iskr_pkg::LEN_NONE;
        n.idle = 1'b0;
        case (r.cmd.opcode)
          iskr_pkg::OP_PAUSE: begin
            if (p2 != 16'h0000) begin
              n.status = iskr_pkg::ST_PARSE;
            end else if (p1 != i_selector) begin
              // only an idle request exists; there is no sleep path
              n.idle_req = 1'b1;
              n.idle = 1'b1;
            end else begin
              n.rand_val = '0;
              n.out_len = iskr_pkg::LEN_BYTE;
            end
          end
          iskr_pkg::OP_NONCE: begin
            if (p1[7:2] != 6'h00 || p1[1:0] == iskr_pkg::NMODE_BAD
                || p2[14:0] != 15'h0000) begin
              n.status = iskr_pkg::ST_PARSE;
            end else if (p1[1:0] == iskr_pkg::NMODE_PASS) begin
              // pass-through: first 32 buffer bytes become the key
              n.temp_key = r.dbuf[7:0];
              n.tk = '{valid: 1'b1, src_input: 1'b1, digest_generation_cmd: 1'b0,
                key_id: 4'h0};
              n.rand_val = '0;
              n.out_len = iskr_pkg::LEN_BYTE;
            end else if (p2[iskr_pkg::NONCE_SUBST_BIT] && !r.tk.valid) begin
              n.status = iskr_pkg::ST_EXEC;
            end else begin
              // random (or temp key) and 36 input bytes (buffer words 0-8) go to the hash
              n.rand_val = p2[iskr_pkg::NONCE_SUBST_BIT] ? r.temp_key
                : rng_word;
              n.seed_upd = p1[1:0] == iskr_pkg::NMODE_SEED;
              n.operand = r.dbuf[iskr_pkg::KEY_WORDS-1:0];
              n.hash_kind = iskr_pkg::HASH_NONCE;
              n.state = iskr_pkg::S_HASH;
              n.busy = 1'b1;
              n.done = 1'b0;
            end
          end
          iskr_pkg::OP_RANDOM: begin
            if (p1[7:1] != 7'h00 || p2 != 16'h0000) begin
              n.status = iskr_pkg::ST_PARSE;
            end else begin
              n.rand_val = rng_word;
              n.seed_upd = !p1[iskr_pkg::RND_KEEP_BIT];
              n.out_len = iskr_pkg::LEN_RAND;
            end
          end
          iskr_pkg::OP_PRIV_WRITE: begin
            // random/auth fields of the key config are never looked at
            if (p1[7] || p1[5:0] != 6'h00 || p2[15:4] != 12'h000) begin
              n.status = iskr_pkg::ST_PARSE;
            end else if (!i_config_locked) begin
              n.status = iskr_pkg::ST_EXEC;
            end else if (!i_slot_cfg.private_key_flag
                || !i_slot_cfg.secret_flag) begin
              n.status = iskr_pkg::ST_EXEC;
            end else if (i_slot_cfg.per_slot_lock) begin
              n.status = iskr_pkg::ST_EXEC;
            end else if (i_data_locked && (i_slot_cfg.write_policy
                != iskr_pkg::WRITE_POLICY_ENCRYPT
                || !p1[iskr_pkg::PW_ENC_BIT])) begin
              n.status = iskr_pkg::ST_EXEC;
            end else if (i_data_locked && (!r.tk.valid || !r.tk.digest_generation_cmd
                || r.tk.key_id != i_slot_cfg.write_key_index)) begin
              n.status = iskr_pkg::ST_EXEC;
            end else if (p1[iskr_pkg::PW_ENC_BIT]) begin
              // encrypted: first hash the temp key for the tail mask
              n.hash_kind = iskr_pkg::HASH_TK;
              n.state = iskr_pkg::S_HASH;
              n.busy = 1'b1;
              n.done = 1'b0;
            end else begin
              // plaintext before data lock: the MAC is not checked
              n.operand = r.dbuf[iskr_pkg::KEY_WORDS-1:0];
              n.key_write = 1'b1;
              n.out_len = iskr_pkg::LEN_BYTE;
            end
          end
          default: begin
            n.status = iskr_pkg::ST_PARSE;
          end
        endcase
      end
      iskr_pkg::S_HASH: begin
        if (i_hash_done) begin
          n.state = iskr_pkg::S_IDLE;
          n.busy = 1'b0;
          n.done = 1'b1;
          n.status = iskr_pkg::ST_OK;
          n.out_len = iskr_pkg::LEN_BYTE;
          unique case (r.hash_kind)
            iskr_pkg::HASH_NONCE: begin
              n.temp_key = i_hash_digest;
              if (p2[iskr_pkg::NONCE_SUBST_BIT]) begin
                n.rand_val = i_hash_digest; // flags stay as they were
              end else begin
                n.tk = '{valid: 1'b1, src_input: 1'b0, digest_generation_cmd: 1'b0,
                  key_id: 4'h0};
              end
              n.out_len = iskr_pkg::LEN_RAND;
            end
            iskr_pkg::HASH_TK: begin
              // undo the host's masking, then verify the MAC
              for (int i = 0; i < 8; i++) begin
                n.operand[i] = r.dbuf[i] ^ r.temp_key[i];
              end
              n.operand[8] = r.dbuf[8] ^ i_hash_digest[31:0];
              n.hash_kind = iskr_pkg::HASH_MAC;
              n.state = iskr_pkg::S_HASH;
              n.busy = 1'b1;
              n.done = 1'b0;
              n.out_len = iskr_pkg::LEN_NONE;
            end
            iskr_pkg::HASH_MAC: begin
              if (i_hash_digest == r.dbuf[16:9]) begin
                n.key_write = 1'b1;
              end else begin
                n.status = iskr_pkg::ST_MAC_FAIL;
                n.out_len = iskr_pkg::LEN_NONE;
              end
            end
            default: begin
              n.status = iskr_pkg::ST_EXEC;
            end
          endcase
        end
      end
    endcase
  end

  // state register; the whole struct clears on reset
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state register
  assign o_slot_index = r.cmd.param2[3:0];
  assign o_seed_update = r.seed_upd;
  assign o_hash_req = r.state == iskr_pkg::S_HASH;
  assign o_hash_kind = r.hash_kind;
  assign o_temp_key = r.temp_key;
  assign o_tk_meta = r.tk;
  assign o_rand_value = r.rand_val;
  assign o_operand = r.operand;
  assign o_cmd = r.cmd;
  assign o_key_write = r.key_write;
  assign o_idle_req = r.idle_req;

  // checks on the sequencer
  logic dec; // a command is being decoded this cycle
  assign dec = r.state == iskr_pkg::S_DECODE;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  nonce_mode_bad_a: assert property (
    dec && r.cmd.opcode == iskr_pkg::OP_NONCE
      && p1[1:0] == iskr_pkg::NMODE_BAD
    |=> r.status == iskr_pkg::ST_PARSE && $stable(r.temp_key)
      && !o_hash_req)
    else $error("invalid nonce mode was accepted");
  nonce_pass_load_a: assert property (
    dec && r.cmd.opcode == iskr_pkg::OP_NONCE && p1 == 8'h03
      && p2 == 16'h0000
    |=> o_temp_key == $past(r.dbuf[7:0]) && o_tk_meta.src_input)
    else $error("pass-through did not load the input");
  nonce_seed_a: assert property (
    dec && r.cmd.opcode == iskr_pkg::OP_NONCE && p1 == 8'h01
    |=> !o_seed_update)
    else $error("seed refreshed in keep-seed mode");
  pause_idle_a: assert property (
    dec && r.cmd.opcode == iskr_pkg::OP_PAUSE && p2 == 16'h0000
      && p1 != i_selector
    |=> o_idle_req && r.out_len == iskr_pkg::LEN_NONE ##1 !o_idle_req)
    else $error("mismatched pause did not idle");
  pause_match_a: assert property (
    dec && r.cmd.opcode == iskr_pkg::OP_PAUSE && p2 == 16'h0000
      && p1 == i_selector
    |=> !o_idle_req && r.status == iskr_pkg::ST_OK
      && r.out_len == iskr_pkg::LEN_BYTE)
    else $error("matching pause did not answer zero");
  idle_cause_a: assert property (
    o_idle_req |-> $past(r.cmd.opcode) == iskr_pkg::OP_PAUSE
      && $past(dec))
    else $error("idle requested outside a pause");
  pw_unlocked_a: assert property (
    dec && r.cmd.opcode == iskr_pkg::OP_PRIV_WRITE && !i_config_locked
    |=> !o_key_write && r.status != iskr_pkg::ST_OK)
    else $error("key write allowed with config unlocked");
  pw_slot_lock_a: assert property (
    dec && r.cmd.opcode == iskr_pkg::OP_PRIV_WRITE
      && i_slot_cfg.per_slot_lock
    |=> !o_key_write ##1 !o_hash_req)
    else $error("key write into a locked slot");
  rng_pattern_a: assert property (
    dec && r.cmd.opcode == iskr_pkg::OP_RANDOM && p1 == 8'h00
      && p2 == 16'h0000 && !i_config_locked
    |=> o_rand_value == {8{iskr_pkg::TEST_PATTERN_WORD}}
      && r.out_len == iskr_pkg::LEN_RAND)
    else $error("test pattern missing before config lock");
  rng_keep_seed_a: assert property (
    dec && r.cmd.opcode == iskr_pkg::OP_RANDOM
    |=> o_seed_update == ($past(p1) == 8'h00 && $past(p2) == 16'h0000))
    else $error("seed refresh does not follow the mode");

  pause_sel_c: cover property (
    dec && r.cmd.opcode == iskr_pkg::OP_PAUSE ##1 o_idle_req);
  nonce_hash_c: cover property (
    o_hash_req && o_hash_kind == iskr_pkg::HASH_NONCE ##[1:8] r.done);
  pw_enc_c: cover property (
    o_hash_kind == iskr_pkg::HASH_MAC && o_hash_req ##[1:8] o_key_write);
  rng_c: cover property (
    dec && r.cmd.opcode == iskr_pkg::OP_RANDOM ##1 r.done);
endmodule

// [testbench/iskr_hash_model.sv]
// hash engine stand-in that answers the interpreter's hash requests
`timescale 1ns/1ps
module iskr_hash_model (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_req,
  input wire logic [1:0] i_kind,
  input wire logic [3:0] i_delay,
  input wire logic [2:0][255:0] i_dig,
  output logic o_done,
  output logic [255:0] o_digest
);
  logic [3:0] cnt_r; // cycles spent on the current request
  logic [255:0] last_r; // digest handed out last
  // answer i_delay + 1 cycles after the request rises; one-cycle done pulse
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_r <= 4'h0;
      o_done <= 1'b0;
      last_r <= '0;
    end else if (o_done || !i_req) begin
      o_done <= 1'b0;
      cnt_r <= 4'h0;
    end else if (cnt_r == i_delay) begin
      o_done <= 1'b1;
      last_r <= i_dig[i_kind];
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  // outside the pulse the digest bus is scrambled, so stale data is useless
  assign o_digest = o_done ? last_r : ~last_r;
endmodule

// [testbench/idle_select_key_write_rng_cmds_test.sv]
// self-checking bench for the command interpreter
`timescale 1ns/1ps
module idle_select_key_write_rng_cmds_test;
  typedef struct packed {
    logic [31:0] cmd; logic cl; logic dl; logic [10:0] cfg;
    logic [7:0] code; logic [5:0] len; logic idle; logic seed;
  } iskr_row_s; // code FF: any error, EE: not checked; len 3F: not checked
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, cl = 0, dl = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, st, q;
  logic pready, pslverr, seed_up, hreq, hdone, kw, idl, e;
  logic gd_load = 0;
  logic [3:0] gd_id = '0, slot_idx, delay = '0;
  logic [255:0] rng, gd_dig = '0, hdig, tkey, rval, t, g;
  logic [2:0][255:0] dig;
  logic [8:0][31:0] pk, kkey;
  logic [7:0][31:0] macw;
  logic [287:0] oper;
  iskr_pkg::iskr_slot_cfg_s slot = '0;
  iskr_pkg::iskr_tk_meta_s tkm;
  iskr_pkg::iskr_cmd_s ocmd;
  logic [1:0] hkind;
  iskr_row_s rows [15];
  int failures = 0, checks = 0, n_idle = 0, n_seed = 0, n_kw = 0, cyc = 0;
  int i0, s0;
  iskr_core u_iskr_core (.i_clk(clk), .i_reset(rst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_selector(8'h5A), .i_config_locked(cl), .i_data_locked(dl),
    .i_slot_cfg(slot), .o_slot_index(slot_idx), .i_rng_data(rng),
    .o_seed_update(seed_up), .i_digest_generation_cmd_load(gd_load),
    .i_digest_generation_cmd_key_id(gd_id), .i_digest_generation_cmd_digest(gd_dig), .o_hash_req(hreq),
    .o_hash_kind(hkind), .i_hash_done(hdone), .i_hash_digest(hdig),
    .o_temp_key(tkey), .o_tk_meta(tkm), .o_rand_value(rval),
    .o_operand(oper), .o_cmd(ocmd), .o_key_write(kw), .o_idle_req(idl));
  iskr_hash_model u_iskr_hash_model (.i_clk(clk), .i_reset(rst),
    .i_req(hreq), .i_kind(hkind), .i_delay(delay), .i_dig(dig),
    .o_done(hdone), .o_digest(hdig));
  // 25 MHz clock
  always #20 clk = ~clk;
  // pulse counters and the watchdog
  always @(posedge clk) begin
    cyc++;
    if (idl === 1'b1) n_idle++;
    if (seed_up === 1'b1) n_seed++;
    if (kw === 1'b1) begin
      n_kw++;
      kkey = oper;
    end
    if (cyc == 20000) begin
      failures++;
      summarize();
    end
  end
  task automatic summarize();
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [287:0] x, y);
    checks++;
    if (y !== x) begin
      failures++;
      $display("Error %s expected %h seen %h", n, x, y);
    end
  endtask
  task automatic chk_code(input logic [7:0] x, y);
    if (x == 8'hFF) chk("error code", 1, y != 8'h00);
    else if (x != 8'hEE) chk("status code", x, y);
  endtask
  // one apb transfer: setup, access held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic er);
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // load the command, start it and poll until done
  task automatic run(input logic [31:0] c);
    apb(1'b1, iskr_pkg::ADDR_CMD, c, q, e);
    apb(1'b1, iskr_pkg::ADDR_CTRL, 32'h0000_0001, q, e);
    for (int n = 0; n < 60; n++) begin
      apb(1'b0, iskr_pkg::ADDR_STATUS, 32'h0000_0000, st, e);
      if (st[1] === 1'b1 && st[0] === 1'b0) break;
    end
  endtask
  task automatic wbuf(input int i, input logic [31:0] d);
    apb(1'b1, iskr_pkg::ADDR_BUF_BASE + 12'(4 * i), d, q, e);
  endtask
  task automatic digest_generation_cmd(input logic [3:0] id);
    @(posedge clk);
    gd_load <= 1'b1; gd_id <= id; gd_dig <= g;
    @(posedge clk);
    gd_load <= 1'b0;
  endtask
  // key write; key data encrypted under tk when enc is set
  task automatic kwr(input logic [255:0] tk, input logic enc,
                     input logic [7:0] ec);
    logic [31:0] w;
    int k0;
    k0 = n_kw;
    for (int i = 0; i < 17; i++) begin
      w = (i < 8) ? pk[i] : (i == 8) ? pk[8] : macw[i - 9];
      if (enc && i < 8) w ^= tk[32 * i +: 32];
      if (enc && i == 8) w ^= dig[1][31:0];
      wbuf(i, w);
    end
    run({16'h0003, 1'b0, enc, 6'h00, iskr_pkg::OP_PRIV_WRITE});
    chk_code(ec, st[15:8]);
    chk("key writes", k0 + (ec == 8'h00), n_kw);
    if (ec == 8'h00) begin
      chk("key", pk, kkey);
      chk("slot", 4'h3, slot_idx);
      chk("len", 1, st[21:16]);
    end
  endtask
  initial begin
    for (int i = 0; i < 8; i++) begin
      rng[32 * i +: 32] = 32'h5A00_0000 + i;
      t[32 * i +: 32] = 32'h7E00_0000 + i;
      g[32 * i +: 32] = 32'h6D00_0000 + i;
      dig[0][32 * i +: 32] = 32'hD000_0000 + i;
      dig[1][32 * i +: 32] = 32'hB100_0000 + i;
      macw[i] = 32'h3C00_0000 + i;
      pk[i + 1] = 32'h9A00_0000 + i;
    end
    pk[0] = 32'h0000_0000; // leading four key bytes are zero
    dig[2] = macw;
    rows[0] = {32'h0000_5A01, 2'b10, 11'h600, 8'h00, 6'h01, 2'b00};
    rows[1] = {32'h0000_A501, 2'b10, 11'h600, 8'hEE, 6'h00, 2'b10};
    rows[2] = {32'h0001_5A01, 2'b10, 11'h600, 8'h03, 6'h3F, 2'b00};
    rows[3] = {32'h0000_001B, 2'b00, 11'h600, 8'h00, 6'h20, 2'b01};
    rows[4] = {32'h0000_011B, 2'b10, 11'h600, 8'h00, 6'h20, 2'b00};
    rows[5] = {32'h0000_021B, 2'b10, 11'h600, 8'h03, 6'h3F, 2'b00};
    rows[6] = {32'h0001_001B, 2'b10, 11'h600, 8'h03, 6'h3F, 2'b00};
    rows[7] = {32'h0000_0216, 2'b10, 11'h600, 8'h03, 6'h3F, 2'b00};
    rows[8] = {32'h0000_0416, 2'b10, 11'h600, 8'h03, 6'h3F, 2'b00};
    rows[9] = {32'h0000_0002, 2'b10, 11'h600, 8'h03, 6'h3F, 2'b00};
    rows[10] = {32'h0003_0046, 2'b00, 11'h600, 8'hFF, 6'h3F, 2'b00};
    rows[11] = {32'h0003_8046, 2'b10, 11'h600, 8'h03, 6'h3F, 2'b00};
    rows[12] = {32'h0003_0046, 2'b10, 11'h700, 8'hFF, 6'h3F, 2'b00};
    rows[13] = {32'h0003_0046, 2'b10, 11'h400, 8'hFF, 6'h3F, 2'b00};
    rows[14] = {32'h0003_0046, 2'b11, 11'h644, 8'hFF, 6'h3F, 2'b00};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, iskr_pkg::ADDR_STATUS, 32'h0000_0000, q, e);
    chk("reset status", 32'h0000_0000, q);
    apb(1'b0, 12'h100, 32'h0000_0000, q, e);
    chk("unmapped error", 1'b1, e);
    foreach (rows[i]) begin
      cl <= rows[i].cl; dl <= rows[i].dl; slot <= rows[i].cfg;
      i0 = n_idle;
      s0 = n_seed;
      run(rows[i].cmd);
      chk_code(rows[i].code, st[15:8]);
      if (rows[i].len != 6'h3F) chk("len", rows[i].len, st[21:16]);
      chk("idle", rows[i].idle, st[2]);
      chk("idle pulses", rows[i].idle, n_idle - i0);
      chk("seed pulses", rows[i].seed, n_seed - s0);
      chk("cmd out", rows[i].cmd, ocmd);
      if (rows[i].len == 6'h20) chk("rand out", rows[i].cl ? rng
          : {8{iskr_pkg::TEST_PATTERN_WORD}}, rval);
      for (int k = 0; k < 8 && rows[i].len == 6'h20; k++) begin
        apb(1'b0, iskr_pkg::ADDR_RES_BASE + 12'(4 * k), 32'h0000_0000, q,
            e);
        chk("random word", rows[i].cl ? rng[32 * k +: 32]
            : iskr_pkg::TEST_PATTERN_WORD, q);
      end
    end
    chk("meta untouched", 7'h00, tkm);
    chk("no key write", 0, n_kw);
    cl <= 1'b1; dl <= 1'b0; slot <= 11'h600;
    for (int m = 0; m < 2; m++) begin
      delay <= m ? 4'h7 : 4'h0;
      s0 = n_seed;
      for (int i = 0; i < 5; i++) wbuf(i, 32'hA0A0_0000 + i);
      run({16'h0000, 8'(m), iskr_pkg::OP_NONCE});
      chk("nonce code", 8'h00, st[15:8]);
      chk("seed pulses", m == 0, n_seed - s0);
      chk("nonce key", dig[0], tkey);
      chk("nonce meta", 2'b10, {tkm.valid, tkm.src_input});
    end
    for (int i = 0; i < 8; i++) wbuf(i, t[32 * i +: 32]);
    run(32'h0000_0316);
    chk("pass code", 8'h00, st[15:8]);
    chk("pass key", t, tkey);
    chk("pass meta", 2'b11, {tkm.valid, tkm.src_input});
    kwr(t, 1'b0, 8'h00);
    kwr(t, 1'b1, 8'h00);
    dig[2] = ~macw;
    kwr(t, 1'b1, iskr_pkg::ST_MAC_FAIL);
    dig[2] = macw;
    dl <= 1'b1;
    slot <= 11'h645;
    digest_generation_cmd(4'h5);
    kwr(g, 1'b1, 8'h00);
    digest_generation_cmd(4'h6);
    kwr(g, 1'b1, 8'hFF);
    slot <= 11'h625;
    digest_generation_cmd(4'h5);
    kwr(g, 1'b1, 8'hFF);
    // reset in mid-run must clear status and the temp key flags
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, iskr_pkg::ADDR_STATUS, 32'h0000_0000, q, e);
    chk("mid-run reset status", 32'h0000_0000, q);
    chk("mid-run reset meta", 7'h00, tkm);
    summarize();
  end
endmodule
